// [hw/fuse_latch_signature_store.sv]
// configuration fuse store, working-copy latch and signature space
// Notes on behaviour
// - extended byte: brown-out level in bits 2:0, default ones, upper bits read one
// - high byte bit 5 enables serial programming, default programmed zero
// - serial programming path cannot change the serial-enable bit
// - high byte bits 7,6,4,0: reset disable, debug, watchdog, vector; default one
// - high byte bit 3 programmed keeps eeprom through chip erase
// - high byte bits 2:1 boot size, default 00 maximum
// - low byte bit 7 divide by eight default zero; bit 6 clock to pin default one
// - low byte bits 5:4 start-up default 10; bits 3:0 clock source default 0010
// - chip erase leaves all fuse bits unchanged
// - fuse writes refused while first lock bit programmed
// - fuses captured on programming entry; writes take effect only after exit
// - eeprom preserve takes effect at once when programmed
// - fuses also captured at power-up in normal mode
// - three identification bytes at signature addresses 0 to 2, readable only in a programming mode
// - calibration byte copied into oscillator trim register during reset
// - flash pages of 64 words: bits 5:0 word, 13:6 page
// - eeprom pages of 4 bytes: bits 1:0 byte, 9:2 page
// - fuse bit reads zero when programmed, one when unprogrammed
`timescale 1ns/1ps
`default_nettype none
`include "fuse_latch_defines.svh"

module fuse_latch_signature_store #(
   parameter logic [7:0] IDENT_BYTE_0 = 8'hA5, // arbitrary value
   parameter logic [7:0] IDENT_BYTE_1 = 8'h5A, // arbitrary value
   parameter logic [7:0] IDENT_BYTE_2 = 8'h3C, // arbitrary value
   parameter logic [7:0] CALIB_DEFAULT = 8'h80
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_prog_serial,
   input wire logic i_prog_parallel,
   input wire logic i_fuse_wr,
   input wire logic [1:0] i_fuse_sel,
   input wire logic [7:0] i_fuse_wdata,
   input wire logic i_chip_erase,
   input wire logic i_fuse_rd,
   input wire logic i_sig_rd,
   input wire logic [1:0] i_sig_addr,
   input wire logic [13:0] i_flash_addr,
   input wire logic [9:0] i_eeprom_addr,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_wr_refused,
   output fuse_latch_pkg::cfg_out_type o_cfg,
   output logic o_eeprom_erase,
   output logic [7:0] o_osc_trim_register,
   output logic [7:0] o_first_lock_state,
   output fuse_latch_pkg::flash_addr_type o_flash_split,
   output fuse_latch_pkg::eeprom_addr_type o_eeprom_split
);

   // ------------------------------------------------------------
   // mode tracking
   // ------------------------------------------------------------
   fuse_latch_pkg::prog_mode_type mode_q;
   fuse_latch_pkg::prog_mode_type mode_d;
   logic boot_q;

   always_comb begin
      if (i_prog_parallel) begin
         mode_d = fuse_latch_pkg::MODE_PARALLEL;
      end else if (i_prog_serial) begin
         mode_d = fuse_latch_pkg::MODE_SERIAL;
      end else begin
         mode_d = fuse_latch_pkg::MODE_NORMAL;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_q <= fuse_latch_pkg::MODE_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   // first clock after reset release counts as power-up
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   logic in_prog;
   logic entering_prog;
   assign in_prog = (mode_q != fuse_latch_pkg::MODE_NORMAL);
   assign entering_prog = !in_prog && (mode_d != fuse_latch_pkg::MODE_NORMAL);

   // ------------------------------------------------------------
   // stored fuse cells and lock byte
   // ------------------------------------------------------------
   fuse_latch_pkg::fuse_set_type cells_q;
   logic [7:0] lock_q;
   logic fuse_locked;
   logic serial_mode;

   assign fuse_locked = !lock_q[`FIRST_LOCK_BIT];
   assign serial_mode = (mode_q == fuse_latch_pkg::MODE_SERIAL);

   // serial path keeps the serial-enable bit, so it cannot lock itself out
   function automatic logic [7:0] merge_high(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic keep_serial);
      logic [7:0] r;
      r = new_v;
      if (keep_serial) begin
         r[`HIGH_SERIAL_PROG_BIT] = old_v[`HIGH_SERIAL_PROG_BIT];
      end
      return r;
   endfunction : merge_high

   logic fuse_wr_ok;
   assign fuse_wr_ok = i_fuse_wr && in_prog && !fuse_locked && (i_fuse_sel != `SEL_LOCK);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cells_q.ext_cfg <= `EXT_CFG_DEFAULT;
         cells_q.high_cfg <= `HIGH_CFG_DEFAULT;
         cells_q.low_cfg <= `LOW_CFG_DEFAULT;
      end else if (fuse_wr_ok) begin
         // chip erase has no path into these cells
         if (i_fuse_sel == `SEL_EXT) begin
            cells_q.ext_cfg <= i_fuse_wdata | `EXT_UNUSED_MASK;
         end else if (i_fuse_sel == `SEL_HIGH) begin
            cells_q.high_cfg <= merge_high(cells_q.high_cfg, i_fuse_wdata, serial_mode);
         end else if (i_fuse_sel == `SEL_LOW) begin
            cells_q.low_cfg <= i_fuse_wdata;
         end
      end
   end

   // lock bits only return to one through chip erase or reset
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         lock_q <= `LOCK_DEFAULT;
      end else if (in_prog && i_chip_erase) begin
         lock_q <= `LOCK_DEFAULT;
      end else if (in_prog && i_fuse_wr && (i_fuse_sel == `SEL_LOCK)) begin
         lock_q <= lock_q & i_fuse_wdata;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wr_refused <= 1'b0;
      end else begin
         o_wr_refused <= i_fuse_wr && in_prog && fuse_locked && (i_fuse_sel != `SEL_LOCK);
      end
   end

   // ------------------------------------------------------------
   // working copies
   // ------------------------------------------------------------
   fuse_latch_pkg::fuse_set_type work_q;
   logic capture;
   // exit also captures so programmed values apply once the mode is left
   assign capture = boot_q || entering_prog || (in_prog && mode_d == fuse_latch_pkg::MODE_NORMAL);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         work_q.ext_cfg <= `EXT_CFG_DEFAULT;
         work_q.high_cfg <= `HIGH_CFG_DEFAULT;
         work_q.low_cfg <= `LOW_CFG_DEFAULT;
      end else if (capture) begin
         work_q <= cells_q;
      end
   end

   function automatic fuse_latch_pkg::cfg_out_type decode_cfg(
      input fuse_latch_pkg::fuse_set_type f);
      fuse_latch_pkg::cfg_out_type c;
      c.brownout_level = f.ext_cfg[2:0];
      c.ext_reset_disable = !f.high_cfg[`HIGH_EXT_RESET_DISABLE_BIT];
      c.debug_link_enable = !f.high_cfg[`HIGH_DEBUG_LINK_BIT];
      c.serial_prog_enable = !f.high_cfg[`HIGH_SERIAL_PROG_BIT];
      c.watchdog_always_on = !f.high_cfg[`HIGH_WATCHDOG_ON_BIT];
      c.eeprom_preserve = !f.high_cfg[`HIGH_EEPROM_PRESERVE_BIT];
      c.boot_size = f.high_cfg[2:1];
      c.reset_vector_select = !f.high_cfg[`HIGH_RESET_VECTOR_BIT];
      c.clock_divide_by_eight = !f.low_cfg[`LOW_CLOCK_DIV8_BIT];
      c.clock_to_pin = !f.low_cfg[`LOW_CLOCK_TO_PIN_BIT];
      c.startup_time = f.low_cfg[5:4];
      c.clock_source = f.low_cfg[3:0];
      return c;
   endfunction : decode_cfg

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cfg <= '0;
      end else begin
         o_cfg <= decode_cfg(work_q);
      end
   end

   // preserve bit bypasses the latch
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_eeprom_erase <= 1'b0;
      end else begin
         o_eeprom_erase <= in_prog && i_chip_erase
            && cells_q.high_cfg[`HIGH_EEPROM_PRESERVE_BIT];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_first_lock_state <= `LOCK_DEFAULT;
      end else begin
         o_first_lock_state <= lock_q;
      end
   end

   // ------------------------------------------------------------
   // oscillator trim
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_osc_trim_register <= CALIB_DEFAULT;
      end else if (boot_q) begin
         o_osc_trim_register <= CALIB_DEFAULT;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   function automatic logic [7:0] sig_byte(input logic [1:0] a);
      logic [7:0] r;
      if (a == `SIG_ADDR_BYTE0) begin
         r = IDENT_BYTE_0;
      end else if (a == `SIG_ADDR_BYTE1) begin
         r = IDENT_BYTE_1;
      end else if (a == `SIG_ADDR_BYTE2) begin
         r = IDENT_BYTE_2;
      end else begin
         r = CALIB_DEFAULT;
      end
      return r;
   endfunction : sig_byte

   logic [7:0] fuse_rd_byte;
   always_comb begin
      if (i_fuse_sel == `SEL_EXT) begin
         fuse_rd_byte = cells_q.ext_cfg | `EXT_UNUSED_MASK;
      end else if (i_fuse_sel == `SEL_HIGH) begin
         fuse_rd_byte = cells_q.high_cfg;
      end else if (i_fuse_sel == `SEL_LOW) begin
         fuse_rd_byte = cells_q.low_cfg;
      end else begin
         fuse_rd_byte = lock_q;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= in_prog && (i_sig_rd || i_fuse_rd);
         if (in_prog && i_sig_rd) begin
            o_rdata <= sig_byte(i_sig_addr);
         end else if (in_prog && i_fuse_rd) begin
            o_rdata <= fuse_rd_byte;
         end
      end
   end

   // ------------------------------------------------------------
   // page address split
   // ------------------------------------------------------------
   page_addr_split u_split (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_flash_addr(i_flash_addr),
      .i_eeprom_addr(i_eeprom_addr),
      .o_flash_split(o_flash_split),
      .o_eeprom_split(o_eeprom_split)
   );

endmodule : fuse_latch_signature_store
`default_nettype wire

// [hw/page_addr_split.sv]
// splits flash word and eeprom byte addresses into page and in-page fields
`timescale 1ns/1ps
`default_nettype none
`include "fuse_latch_defines.svh"

module page_addr_split (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [13:0] i_flash_addr,
   input wire logic [9:0] i_eeprom_addr,
   output fuse_latch_pkg::flash_addr_type o_flash_split,
   output fuse_latch_pkg::eeprom_addr_type o_eeprom_split
);

   fuse_latch_pkg::flash_addr_type flash_q;
   fuse_latch_pkg::eeprom_addr_type eeprom_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         flash_q <= '0;
      end else begin
         flash_q.flash_word_in_page <= i_flash_addr[`FLASH_WORD_MSB:`FLASH_WORD_LSB];
         flash_q.flash_page_index <= i_flash_addr[`FLASH_ADDR_TOP_BIT:`FLASH_PAGE_LSB];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         eeprom_q <= '0;
      end else begin
         eeprom_q.eeprom_byte_in_page <= i_eeprom_addr[`EEPROM_BYTE_MSB:`EEPROM_BYTE_LSB];
         eeprom_q.eeprom_page_index <=
            i_eeprom_addr[`EEPROM_ADDR_TOP_BIT:`EEPROM_PAGE_LSB];
      end
   end

   assign o_flash_split = flash_q;
   assign o_eeprom_split = eeprom_q;

endmodule : page_addr_split
`default_nettype wire

// [include/fuse_latch_defines.svh]
// constants for the configuration fuse latch and signature store
`ifndef FUSE_LATCH_DEFINES_SVH
`define FUSE_LATCH_DEFINES_SVH

`define EXT_CFG_DEFAULT 8'hFF
`define HIGH_CFG_DEFAULT 8'hD9
`define LOW_CFG_DEFAULT 8'h62
`define EXT_UNUSED_MASK 8'hF8
`define HIGH_EXT_RESET_DISABLE_BIT 7
`define HIGH_DEBUG_LINK_BIT 6
`define HIGH_SERIAL_PROG_BIT 5
`define HIGH_WATCHDOG_ON_BIT 4
`define HIGH_EEPROM_PRESERVE_BIT 3
`define HIGH_RESET_VECTOR_BIT 0
`define LOW_CLOCK_DIV8_BIT 7
`define LOW_CLOCK_TO_PIN_BIT 6
`define SIG_ADDR_BYTE0 2'h0
`define SIG_ADDR_BYTE1 2'h1
`define SIG_ADDR_BYTE2 2'h2
`define SIG_ADDR_CALIB 2'h3
`define SEL_EXT 2'h0
`define SEL_HIGH 2'h1
`define SEL_LOW 2'h2
`define SEL_LOCK 2'h3
`define LOCK_DEFAULT 8'hFF
`define FIRST_LOCK_BIT 0
`define FLASH_WORD_LSB 0
`define FLASH_WORD_MSB 5
`define FLASH_PAGE_LSB 6
`define FLASH_ADDR_TOP_BIT 13
`define EEPROM_BYTE_LSB 0
`define EEPROM_BYTE_MSB 1
`define EEPROM_PAGE_LSB 2
`define EEPROM_ADDR_TOP_BIT 9

`endif

// [include/fuse_latch_pkg.sv]
// types for the configuration fuse latch and signature store
package fuse_latch_pkg;

   typedef struct packed {
      logic [7:0] ext_cfg;
      logic [7:0] high_cfg;
      logic [7:0] low_cfg;
   } fuse_set_type;

   typedef struct packed {
      logic [2:0] brownout_level;
      logic ext_reset_disable;
      logic debug_link_enable;
      logic serial_prog_enable;
      logic watchdog_always_on;
      logic eeprom_preserve;
      logic [1:0] boot_size;
      logic reset_vector_select;
      logic clock_divide_by_eight;
      logic clock_to_pin;
      logic [1:0] startup_time;
      logic [3:0] clock_source;
   } cfg_out_type;

   typedef struct packed {
      logic [7:0] flash_page_index;
      logic [5:0] flash_word_in_page;
   } flash_addr_type;

   typedef struct packed {
      logic [7:0] eeprom_page_index;
      logic [1:0] eeprom_byte_in_page;
   } eeprom_addr_type;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_SERIAL,
      MODE_PARALLEL
   } prog_mode_type;

endpackage : fuse_latch_pkg

// [testbench/fuse_latch_signature_store_sva.sv]
// assertion checker for the fuse latch and signature store
`timescale 1ns/1ps
`default_nettype none
module fuse_latch_checker #(
   parameter logic [7:0] IDENT_BYTE_0 = 8'hA5, // arbitrary value
   parameter logic [7:0] CALIB_DEFAULT = 8'h80
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_prog_serial,
   input wire logic i_prog_parallel,
   input wire logic i_fuse_wr,
   input wire logic [1:0] i_fuse_sel,
   input wire logic i_chip_erase,
   input wire logic i_fuse_rd,
   input wire logic i_sig_rd,
   input wire logic [1:0] i_sig_addr,
   input wire logic [13:0] i_flash_addr,
   input wire logic [7:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic o_wr_refused,
   input wire fuse_latch_pkg::cfg_out_type o_cfg,
   input wire logic o_eeprom_erase,
   input wire logic [7:0] o_osc_trim_register,
   input wire logic [7:0] o_first_lock_state,
   input wire fuse_latch_pkg::flash_addr_type o_flash_split
);
   logic prog_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         prog_q <= 1'b0;
      end else begin
         prog_q <= i_prog_serial | i_prog_parallel;
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence s_sig0_req;
      prog_q && i_sig_rd && !i_fuse_rd && i_sig_addr == 2'h0;
   endsequence
   sequence s_ext_rd;
      prog_q && i_fuse_rd && !i_sig_rd && i_fuse_sel == 2'h0;
   endsequence
   // lock output lags one cycle, so skip the edge right after an erase
   sequence s_locked_wr;
      prog_q && i_fuse_wr && i_fuse_sel != 2'h3 && !o_first_lock_state[0] && !$past(i_chip_erase);
   endsequence
   a_sig_byte_read: assert property (s_sig0_req |=> o_rvalid && o_rdata == IDENT_BYTE_0)
      else $error("signature byte 0 read wrong");
   a_ext_upper_ones: assert property (s_ext_rd |=> o_rvalid && o_rdata[7:3] == 5'h1F)
      else $error("extended byte upper bits not one");
   a_locked_refuse: assert property (s_locked_wr |=> o_wr_refused)
      else $error("locked fuse write not refused");
   a_refuse_cause: assert property (o_wr_refused |-> $past(i_fuse_wr && prog_q))
      else $error("refusal without write");
   a_erase_cause: assert property (o_eeprom_erase |-> $past(i_chip_erase && prog_q))
      else $error("eeprom erase without chip erase");
   a_trim_value: assert property (o_osc_trim_register == CALIB_DEFAULT)
      else $error("trim register not calibration value");
   a_cfg_held_prog: assert property (prog_q [*3] |=> $stable(o_cfg))
      else $error("working configuration moved in programming");
   a_flash_split: assert property (!$past(i_rst) |-> o_flash_split == $past(i_flash_addr))
      else $error("flash address split wrong");
endmodule : fuse_latch_checker
bind fuse_latch_signature_store fuse_latch_checker #(
   .IDENT_BYTE_0(IDENT_BYTE_0), .CALIB_DEFAULT(CALIB_DEFAULT)
) u_chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_prog_serial(i_prog_serial),
   .i_prog_parallel(i_prog_parallel), .i_fuse_wr(i_fuse_wr), .i_fuse_sel(i_fuse_sel),
   .i_chip_erase(i_chip_erase), .i_fuse_rd(i_fuse_rd), .i_sig_rd(i_sig_rd),
   .i_sig_addr(i_sig_addr), .i_flash_addr(i_flash_addr), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .o_wr_refused(o_wr_refused), .o_cfg(o_cfg),
   .o_eeprom_erase(o_eeprom_erase), .o_osc_trim_register(o_osc_trim_register),
   .o_first_lock_state(o_first_lock_state), .o_flash_split(o_flash_split)
);
`default_nettype wire

// [testbench/prog_host.sv]
// programming host model driving fuse, lock and signature requests
`timescale 1ns/1ps
`default_nettype none
module prog_host (
   input wire logic i_sys_clk,
   output logic o_ser,
   output logic o_par,
   output logic o_wr,
   output logic o_rd,
   output logic o_sig,
   output logic o_erase,
   output logic [1:0] o_sel,
   output logic [7:0] o_data
);
   initial {o_ser, o_par, o_wr, o_rd, o_sig, o_erase, o_sel, o_data} = '0;
   // mode lands a cycle late and capture lags further, so settle long
   task automatic mode(input logic ser, input logic par);
      @(posedge i_sys_clk) #1;
      o_ser = ser;
      o_par = par;
      repeat (4) @(posedge i_sys_clk);
      #1;
   endtask : mode
   // released data lines flip so stale values never look valid
   task automatic op(input logic [3:0] kind, input logic [1:0] sel, input logic [7:0] data);
      @(posedge i_sys_clk) #1;
      {o_wr, o_rd, o_sig, o_erase} = kind;
      o_sel = sel;
      o_data = data;
      @(posedge i_sys_clk) #1;
      {o_wr, o_rd, o_sig, o_erase} = 4'h0;
      o_sel = ~sel;
      o_data = ~data;
   endtask : op
endmodule : prog_host
`default_nettype wire

// [testbench/tb_fuse_latch_signature_store.sv]
// self-checking testbench for the fuse latch and signature store
`timescale 1ns/1ps
`default_nettype none
module tb_fuse_latch_signature_store;
   localparam logic [7:0] ID0 = 8'h96; // arbitrary value
   localparam logic [7:0] ID1 = 8'h69; // arbitrary value
   localparam logic [7:0] ID2 = 8'hC3; // arbitrary value
   localparam logic [7:0] CAL = 8'h47;
   localparam logic [3:0] WR = 4'h8, RD = 4'h4, SIG = 4'h2, ERASE = 4'h1;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic ser, par, wr, rd, sig, erase, rvalid, refused, ee_erase;
   logic [1:0] sel;
   logic [7:0] data, rdata, trim, lock;
   logic [13:0] faddr = 14'h0000;
   logic [9:0] eaddr = 10'h000;
   fuse_latch_pkg::cfg_out_type cfg;
   fuse_latch_pkg::flash_addr_type fsplit;
   fuse_latch_pkg::eeprom_addr_type esplit;
   int fails = 0;
   int comparisons = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   prog_host u_host (.i_sys_clk(i_sys_clk), .o_ser(ser), .o_par(par), .o_wr(wr), .o_rd(rd),
      .o_sig(sig), .o_erase(erase), .o_sel(sel), .o_data(data));
   fuse_latch_signature_store #(.IDENT_BYTE_0(ID0), .IDENT_BYTE_1(ID1), .IDENT_BYTE_2(ID2),
      .CALIB_DEFAULT(CAL)) u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_prog_serial(ser),
      .i_prog_parallel(par), .i_fuse_wr(wr), .i_fuse_sel(sel), .i_fuse_wdata(data),
      .i_chip_erase(erase), .i_fuse_rd(rd), .i_sig_rd(sig), .i_sig_addr(sel),
      .i_flash_addr(faddr), .i_eeprom_addr(eaddr), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_wr_refused(refused), .o_cfg(cfg), .o_eeprom_erase(ee_erase),
      .o_osc_trim_register(trim), .o_first_lock_state(lock), .o_flash_split(fsplit),
      .o_eeprom_split(esplit));
   // zero means programmed, outputs are one when the feature is on
   function automatic fuse_latch_pkg::cfg_out_type cfg_of(input logic [7:0] e, h, l);
      cfg_of = {e[2:0], ~h[7], ~h[6], ~h[5], ~h[4], ~h[3], h[2:1], ~h[0], ~l[7], ~l[6], l[5:0]};
   endfunction : cfg_of
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic rd_chk(input logic [3:0] kind, input logic [1:0] s, input logic [7:0] exp,
      input string what);
      u_host.op(kind, s, 8'h00);
      chk(19'(rvalid), 19'h1, "rvalid");
      chk(19'(rdata), 19'(exp), what);
   endtask : rd_chk
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_split;
      logic [13:0] fa[3] = '{14'h0000, 14'h3FFF, 14'h2A95};
      logic [9:0] ea[3] = '{10'h3FF, 10'h000, 10'h156};
      for (int k = 0; k < 3; k++) begin
         faddr = fa[k];
         eaddr = ea[k];
         @(posedge i_sys_clk) #1;
         chk(19'(fsplit.flash_page_index), 19'(fa[k][13:6]), "fpage");
         chk(19'(fsplit.flash_word_in_page), 19'(fa[k][5:0]), "fword");
         chk(19'(esplit.eeprom_page_index), 19'(ea[k][9:2]), "epage");
         chk(19'(esplit.eeprom_byte_in_page), 19'(ea[k][1:0]), "ebyte");
      end
   endtask : t_split
   task automatic t_defaults;
      chk(19'(cfg), 19'(cfg_of(8'hFF, 8'hD9, 8'h62)), "cfg");
      chk(19'(trim), 19'(CAL), "trim");
      u_host.mode(1'b0, 1'b1);
      rd_chk(RD, 2'h0, 8'hFF, "ext");
      rd_chk(RD, 2'h1, 8'hD9, "high");
      rd_chk(RD, 2'h2, 8'h62, "low");
      rd_chk(SIG, 2'h0, ID0, "sig0");
      rd_chk(SIG, 2'h1, ID1, "sig1");
      rd_chk(SIG, 2'h2, ID2, "sig2");
      rd_chk(SIG, 2'h3, CAL, "calib");
   endtask : t_defaults
   task automatic t_latch;
      u_host.op(ERASE, 2'h0, 8'h00);
      chk(19'(ee_erase), 19'h1, "erase");
      rd_chk(RD, 2'h1, 8'hD9, "high");
      u_host.op(WR, 2'h0, 8'h00);
      u_host.op(WR, 2'h1, 8'h00);
      u_host.op(WR, 2'h2, 8'hFF);
      rd_chk(RD, 2'h0, 8'hF8, "ext");
      chk(19'(cfg), 19'(cfg_of(8'hFF, 8'hD9, 8'h62)), "cfg");
      u_host.op(ERASE, 2'h0, 8'h00);
      chk(19'(ee_erase), 19'h0, "erase");
      u_host.mode(1'b0, 1'b0);
      chk(19'(cfg), 19'(cfg_of(8'hF8, 8'h00, 8'hFF)), "cfg");
   endtask : t_latch
   task automatic t_serial;
      u_host.mode(1'b1, 1'b0);
      u_host.op(WR, 2'h1, 8'h20);
      rd_chk(RD, 2'h1, 8'h00, "high");
      u_host.mode(1'b0, 1'b1);
      u_host.op(WR, 2'h1, 8'h20);
      rd_chk(RD, 2'h1, 8'h20, "high");
   endtask : t_serial
   task automatic t_lock;
      u_host.op(WR, 2'h3, 8'hFE);
      @(posedge i_sys_clk) #1;
      chk(19'(lock), 19'hFE, "lock");
      u_host.op(WR, 2'h2, 8'h00);
      chk(19'(refused), 19'h1, "refused");
      rd_chk(RD, 2'h2, 8'hFF, "low");
      u_host.op(ERASE, 2'h0, 8'h00);
      u_host.op(WR, 2'h2, 8'h00);
      chk(19'(refused), 19'h0, "refused");
      rd_chk(RD, 2'h2, 8'h00, "low");
      chk(19'(lock), 19'hFF, "lock");
      u_host.mode(1'b0, 1'b0);
   endtask : t_lock
   task automatic print_verdict;
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(posedge i_sys_clk);
      #1;
      i_rst = 1'b0;
      repeat (4) @(posedge i_sys_clk);
      #1;
      t_split();
      t_defaults();
      t_latch();
      t_serial();
      t_lock();
      print_verdict();
   end
   initial begin
      #200000;
      fails++;
      print_verdict();
   end
endmodule : tb_fuse_latch_signature_store
`default_nettype wire
